// ===== scf_pkg.sv
package scf_pkg;
  // ----------------------------------------
  // Field positions of configuration bytes
  // ----------------------------------------
  localparam int POL_LO = 4;
  localparam int POL_HI = 5;
  localparam int CLAMP_POL_LO = 6;
  localparam int CLAMP_POL_HI = 7;
  localparam int COAST_POL_LO = 6;
  localparam int COAST_POL_HI = 7;
  localparam int CLAMP_EXT_BIT = 4;
  localparam int EXT_CLK_BIT = 2;
  localparam int PD_CTRL_BIT = 3;
  localparam int PD_MANUAL_BIT = 4;
  localparam int PD_PINPOL_BIT = 2;
  // ----------------------------------------
  // Reset values and limits
  // ----------------------------------------
  localparam logic [7:0] CLAMP_CFG_RST = 8'h00;
  localparam logic [7:0] COAST_POL_RST = 8'hc0;
  localparam logic [4:0] SLICE_RST = 5'h0f;
  localparam int SLICE_STEP_MV = 8;
  localparam int PHASE_TAPS = 32;
  localparam logic [1:0] POL_AUTO = 2'h0;
  localparam logic [1:0] POL_LOW = 2'h2;
  localparam logic [1:0] POL_HIGH = 2'h3;
  localparam int CNT_W = 12;

  typedef struct packed {
    logic line_sync;
    logic frame_sync;
    logic green_sync;
  } scf_sync_t;
endpackage

// ===== scf_front_end.sv
`timescale 1ns/1ps
// Function
// - Line sync sense is automatic or manual from bits 5:4 of byte 0x12.
// - Leading line edge drives the lock pulse; trailing edge times the clamp.
// - Polarity 0 uses the falling edge, polarity 1 the rising edge.
// - Frame sync sense is automatic or manual from bits 5:4 of byte 0x14.
// - Frame sync drives the field flag and the internal coast window.
// - Slicer threshold in 8 mV steps, 8 to 256 mV, 128 mV after reset.
// - Slicer output is a non-inverted copy of the embedded green sync.
// - External clamp pin honoured only when bit 4 of 0x18 is set; resets 0.
// - Without external clamp, window is delay then duration after trailing edge.
// - Clamp pin sense is automatic or manual from bits 7:6 of 0x1B.
// - Bit 2 of 0x03 selects the external clock instead of the PLL clock.
// - During coast, stop tracking line sync and hold frequency and phase.
// - Coast sense is automatic or from bits 7:6 of 0x18; defaults to 1.
// - Bit 4 of 0x1E selects manual power-down; bit 3 forces it, else the pin with sense from bit 2 controls it.
// - Regenerated line sync is aligned with data clock; polarity and width set.
// - Phase change moves data clock and line sync output together.
module scf_front_end (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic line_sync_in_a,
  input wire logic line_sync_in_b,
  input wire logic frame_sync_in_a,
  input wire logic frame_sync_in_b,
  input wire logic green_embedded_sync_in_a,
  input wire logic green_embedded_sync_in_b,
  input wire logic channel_sel,
  input wire logic ext_clamp_in,
  input wire logic coast_in,
  input wire logic external_pixel_clock_in,
  input wire logic power_down_pin,
  input wire logic [7:0] line_pol_cfg,
  input wire logic [7:0] frame_pol_cfg,
  input wire logic [7:0] clamp_coast_cfg,
  input wire logic [7:0] clamp_pol_cfg,
  input wire logic [7:0] clk_cfg,
  input wire logic [7:0] pd_cfg,
  input wire logic [4:0] slice_level,
  input wire logic slice_level_wr,
  input wire logic [7:0] clamp_delay,
  input wire logic [7:0] clamp_width,
  input wire logic [7:0] hs_out_width,
  input wire logic hs_out_pol,
  input wire logic [4:0] phase_sel,
  input wire logic pll_clk_tick,
  output logic sliced_sync_out,
  output logic aligned_line_sync_out,
  output logic pixel_data_clock_out,
  output logic clamp_window,
  output logic coast_active,
  output logic pll_lock_pulse,
  output logic field_odd,
  output logic power_down,
  output logic ext_clock_sel,
  output logic line_pol_detected,
  output logic [4:0] slice_threshold,
  output logic [4:0] phase_applied
);
  import scf_pkg::*;

  // ----------------------------------------
  // Input selection and polarity
  // ----------------------------------------
  scf_sync_t sel_w;
  assign sel_w.line_sync = channel_sel ? line_sync_in_b : line_sync_in_a;
  assign sel_w.frame_sync = channel_sel ? frame_sync_in_b : frame_sync_in_a;
  assign sel_w.green_sync = channel_sel ? green_embedded_sync_in_b : green_embedded_sync_in_a;

  scf_sync_t prev_r;
  logic [3:0] auto_pol_w;
  logic [3:0] raw_w;
  logic [3:0] pol_w;
  logic [3:0] act_w;
  logic [3:0] act_prev_r;
  logic [7:0] mode_w;
  assign raw_w = {coast_in, ext_clamp_in, sel_w.frame_sync, sel_w.line_sync};
  assign mode_w = {clamp_coast_cfg[COAST_POL_HI:COAST_POL_LO], clamp_pol_cfg[CLAMP_POL_HI:CLAMP_POL_LO],
                   frame_pol_cfg[POL_HI:POL_LO], line_pol_cfg[POL_HI:POL_LO]};

  // Line, frame, clamp and coast inputs each get their own sense detector, active-high after correction.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pol
      logic [CNT_W-1:0] hi_cnt_r;
      logic [CNT_W-1:0] lo_cnt_r;
      logic det_r;
      logic raw_prev_r;
      logic [1:0] md_w;
      assign md_w = mode_w[2*gi+1:2*gi];
      // Short phase is the pulse: active high when the high time is shorter.
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          hi_cnt_r <= '0;
          lo_cnt_r <= '0;
          det_r <= 1'b1;
          raw_prev_r <= 1'b0;
        end else if (clk_en) begin
          raw_prev_r <= raw_w[gi];
          if (raw_w[gi] && !raw_prev_r) begin
            det_r <= (hi_cnt_r < lo_cnt_r);
            hi_cnt_r <= '0;
            lo_cnt_r <= '0;
          end else if (raw_w[gi]) begin
            hi_cnt_r <= (&hi_cnt_r) ? hi_cnt_r : hi_cnt_r + 1'b1;
          end else begin
            lo_cnt_r <= (&lo_cnt_r) ? lo_cnt_r : lo_cnt_r + 1'b1;
          end
        end
      end
      assign auto_pol_w[gi] = det_r;
      // Manual 0 takes the falling edge as active, manual 1 the rising edge.
      assign pol_w[gi] = (md_w == POL_AUTO) ? det_r : md_w[0];
      assign act_w[gi] = pol_w[gi] ? raw_w[gi] : ~raw_w[gi];
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      act_prev_r <= '0;
      prev_r <= '0;
    end else if (clk_en) begin
      act_prev_r <= act_w;
      prev_r <= sel_w;
    end
  end

  wire line_lead_w = act_w[0] & ~act_prev_r[0];
  wire line_trail_w = ~act_w[0] & act_prev_r[0];
  wire frame_lead_w = act_w[1] & ~act_prev_r[1];

  // ----------------------------------------
  // Clamp window and coast
  // ----------------------------------------
  typedef enum logic [1:0] {CL_IDLE, CL_DELAY, CL_HOLD} scf_clamp_t;
  scf_clamp_t cl_r;
  scf_clamp_t cl_nxt;
  logic [7:0] cl_cnt_r;
  wire ext_clamp_en_w = clamp_coast_cfg[CLAMP_EXT_BIT];
  wire cl_done_w = (cl_cnt_r == 8'h00);

  always_comb begin
    cl_nxt = cl_r;
    case (cl_r)
      CL_IDLE: if (line_trail_w) cl_nxt = CL_DELAY;
      CL_DELAY: if (cl_done_w) cl_nxt = CL_HOLD;
      CL_HOLD: if (cl_done_w) cl_nxt = CL_IDLE;
      default: cl_nxt = CL_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cl_r <= CL_IDLE;
      cl_cnt_r <= 8'h00;
    end else if (clk_en) begin
      cl_r <= cl_nxt;
      if (cl_r == CL_IDLE) cl_cnt_r <= clamp_delay;
      else if (cl_r == CL_DELAY && cl_done_w) cl_cnt_r <= clamp_width;
      else if (!cl_done_w) cl_cnt_r <= cl_cnt_r - 8'h01;
    end
  end

  // External pin used only when enabled, otherwise the internal window.
  wire clamp_nxt_w = ext_clamp_en_w ? act_w[2] : (cl_r == CL_HOLD);

  // Internal coast spans from the frame leading edge to its end.
  wire coast_nxt_w = act_w[3] | act_w[1];

  // ----------------------------------------
  // Regenerated line sync and data clock
  // ----------------------------------------
  logic [7:0] hs_cnt_r;
  logic field_r;
  logic [4:0] slice_r;
  logic [4:0] phase_r;
  logic [PHASE_TAPS-1:0] hs_tap_r;
  logic [PHASE_TAPS-1:0] ck_tap_r;
  logic pix_ck_r;
  wire pix_src_w = clk_cfg[EXT_CLK_BIT] ? external_pixel_clock_in : pll_clk_tick;
  wire hs_pulse_w = (hs_cnt_r != 8'h00);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hs_cnt_r <= 8'h00;
      field_r <= 1'b0;
      slice_r <= SLICE_RST;
      phase_r <= 5'h00;
      hs_tap_r <= '0;
      ck_tap_r <= '0;
      pix_ck_r <= 1'b0;
    end else if (clk_en) begin
      if (line_lead_w) hs_cnt_r <= hs_out_width;
      else if (hs_pulse_w) hs_cnt_r <= hs_cnt_r - 8'h01;
      if (frame_lead_w) field_r <= act_w[0];
      if (slice_level_wr) slice_r <= slice_level;
      phase_r <= phase_sel;
      pix_ck_r <= pix_src_w;
      hs_tap_r <= {hs_tap_r[PHASE_TAPS-2:0], hs_pulse_w};
      ck_tap_r <= {ck_tap_r[PHASE_TAPS-2:0], pix_ck_r};
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  wire pd_nxt_w = pd_cfg[PD_MANUAL_BIT] &
                  (pd_cfg[PD_CTRL_BIT] | (power_down_pin == pd_cfg[PD_PINPOL_BIT]));

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sliced_sync_out <= 1'b0;
      aligned_line_sync_out <= 1'b0;
      pixel_data_clock_out <= 1'b0;
      clamp_window <= 1'b0;
      coast_active <= 1'b0;
      pll_lock_pulse <= 1'b0;
      field_odd <= 1'b0;
      power_down <= 1'b0;
      ext_clock_sel <= 1'b0;
      line_pol_detected <= 1'b1;
      slice_threshold <= SLICE_RST;
      phase_applied <= 5'h00;
    end else if (clk_en) begin
      sliced_sync_out <= prev_r.green_sync;
      aligned_line_sync_out <= hs_tap_r[phase_r] ^ ~hs_out_pol;
      pixel_data_clock_out <= ck_tap_r[phase_r];
      clamp_window <= clamp_nxt_w;
      coast_active <= coast_nxt_w;
      pll_lock_pulse <= line_lead_w & ~coast_nxt_w;
      field_odd <= field_r;
      power_down <= pd_nxt_w;
      ext_clock_sel <= clk_cfg[EXT_CLK_BIT];
      line_pol_detected <= auto_pol_w[0];
      slice_threshold <= slice_r;
      phase_applied <= phase_r;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_ext_clamp_off: assert property (@(posedge clk_sys) disable iff (rst)
    clk_en && !ext_clamp_en_w && cl_r == CL_IDLE |=> !clamp_window)
    else $error("Clamp window rose with no internal window.");
  a_lock_leading: assert property (@(posedge clk_sys) disable iff (rst)
    pll_lock_pulse && $past(clk_en) |-> $past(line_lead_w))
    else $error("Lock pulse without leading edge.");
  a_coast_hold: assert property (@(posedge clk_sys) disable iff (rst)
    clk_en && coast_nxt_w |=> !pll_lock_pulse)
    else $error("Lock pulse during coast.");
  a_clamp_start: assert property (@(posedge clk_sys) disable iff (rst)
    clk_en && cl_r == CL_IDLE && line_trail_w |=> cl_r == CL_DELAY)
    else $error("Clamp delay did not start on trailing edge.");
  a_ext_clk_sel: assert property (@(posedge clk_sys) disable iff (rst)
    clk_en |=> ext_clock_sel == $past(clk_cfg[EXT_CLK_BIT]))
    else $error("Clock select mismatch.");
  a_pd_manual: assert property (@(posedge clk_sys) disable iff (rst)
    clk_en && !pd_cfg[PD_MANUAL_BIT] |=> !power_down)
    else $error("Power-down without manual mode.");
  a_slice_copy: assert property (@(posedge clk_sys) disable iff (rst)
    clk_en ##1 clk_en |=> sliced_sync_out == $past(sel_w.green_sync, 2))
    else $error("Slicer output not a copy.");
  a_pol_manual: assert property (@(posedge clk_sys) disable iff (rst)
    line_pol_cfg[POL_HI:POL_LO] == POL_LOW |-> act_w[0] == ~sel_w.line_sync)
    else $error("Manual falling polarity not applied.");
  c_clamp_run: cover property (@(posedge clk_sys) cl_r == CL_DELAY ##[1:300] cl_r == CL_HOLD);
  c_coast: cover property (@(posedge clk_sys) coast_active);
  c_lock: cover property (@(posedge clk_sys) pll_lock_pulse);
endmodule // scf_front_end

// ===== scf_src_model.sv
`timescale 1ns/1ps
module scf_src_model #(
  parameter int PERIOD = 40,
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic run,
  input wire logic act_high,
  input wire logic frame_on,
  output scf_pkg::scf_sync_t sync_o
);
  import scf_pkg::*;
  int cnt = 0;
  logic pulse;
  // ----------------------------------------
  // Line pulse train
  // ----------------------------------------
  always @(posedge clk_sys) begin
    cnt <= #1 run ? (cnt + 1) % PERIOD : 0;
  end
  assign pulse = run && (cnt < WIDTH);
  assign sync_o.line_sync = act_high ? pulse : !pulse;
  assign sync_o.frame_sync = frame_on;
  assign sync_o.green_sync = !pulse;
endmodule // scf_src_model

// ===== tb_sync_clamp_coast_front_end.sv
`timescale 1ns/1ps
module tb_sync_clamp_coast_front_end;
  import scf_pkg::*;
  logic clk_sys = 0, rst = 1, tick = 0, run = 0, act_high = 1, frame_on = 0;
  logic chan = 0, ext_clamp_in = 0, coast_in = 0, pd_pin = 0, wr = 0, hs_pol = 0;
  logic [7:0] lp = 0, fp = 0, ccc = 0, cpc = 0, ckc = 0, pdc = 0, dly = 4, wid = 6, hw = 3;
  logic [4:0] lvl = 0, ph = 0, thr, pha;
  logic sliced, hs_o, dck, clamp_window, coast_active, lock, field_odd, power_down, ext_sel, pol_det;
  logic exp_lvl = 1;
  scf_sync_t sy;
  int bad_count = 0, n_compared = 0, n_lock = 0, wrong_lvl = 0, n_clamp = 0;
  logic en = 1, pll_tick = 0, hs_prev = 0, dck_prev = 0, dck_at = 0, dck_ref = 0;
  int n_hs = 0, n_dck = 0, since_lock = 0, lag = 0;
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) tick <= #1 ~tick;
  always @(posedge clk_sys) if (tick) pll_tick <= #1 ~pll_tick;
  scf_src_model src_u (.clk_sys(clk_sys), .run(run), .act_high(act_high), .frame_on(frame_on), .sync_o(sy));
  scf_front_end dut_u (.clk_sys(clk_sys), .rst(rst), .clk_en(en), .line_sync_in_a(sy.line_sync),
    .line_sync_in_b(sy.line_sync), .frame_sync_in_a(sy.frame_sync), .frame_sync_in_b(sy.frame_sync),
    .green_embedded_sync_in_a(sy.green_sync), .green_embedded_sync_in_b(sy.green_sync), .channel_sel(chan),
    .ext_clamp_in(ext_clamp_in), .coast_in(coast_in), .external_pixel_clock_in(tick), .power_down_pin(pd_pin),
    .line_pol_cfg(lp), .frame_pol_cfg(fp), .clamp_coast_cfg(ccc), .clamp_pol_cfg(cpc), .clk_cfg(ckc),
    .pd_cfg(pdc), .slice_level(lvl), .slice_level_wr(wr), .clamp_delay(dly), .clamp_width(wid),
    .hs_out_width(hw), .hs_out_pol(hs_pol), .phase_sel(ph), .pll_clk_tick(pll_tick), .sliced_sync_out(sliced),
    .aligned_line_sync_out(hs_o), .pixel_data_clock_out(dck), .clamp_window(clamp_window),
    .coast_active(coast_active), .pll_lock_pulse(lock), .field_odd(field_odd), .power_down(power_down),
    .ext_clock_sel(ext_sel), .line_pol_detected(pol_det), .slice_threshold(thr), .phase_applied(pha));
  // ----------------------------------------
  // Monitors
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (lock === 1'b1) begin
      n_lock++;
      since_lock = 0;
      if (sy.line_sync !== exp_lvl) wrong_lvl++;
    end else begin
      since_lock++;
    end
    if (clamp_window === 1'b1) n_clamp++;
    if (hs_o === hs_pol) n_hs++;
    // The onset of the regenerated pulse is timed from the lock pulse, with the clock level beside it.
    if (hs_o === hs_pol && hs_prev !== hs_pol) begin
      lag = since_lock;
      dck_at = dck;
    end
    hs_prev = hs_o;
    if (dck !== dck_prev) n_dck++;
    dck_prev = dck;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic lines(input logic [7:0] cfg, input logic hi, input logic l);
    lp = cfg;
    act_high = hi;
    exp_lvl = l;
    cyc(200);
    n_lock = 0;
    wrong_lvl = 0;
    n_hs = 0;
    n_dck = 0;
    cyc(400);
    chk("lock_count", 8'(n_lock >= 9 && n_lock <= 11), 8'h01);
    chk("lock_edge", 8'(wrong_lvl), 8'h00);
    chk("hs_width", 8'(n_hs), 8'h1e);
    chk("dck_toggle", 8'(n_dck == 400), 8'h01);
  endtask
  initial begin
    #(20 * 100000);
    bad_count++;
    test_done();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    cyc(12);
    rst = 0;
    cyc(1);
    chk("slice_rst", 8'(thr), 8'h0f);
    chk("pol_rst", 8'(pol_det), 8'h01);
    chk("clamp_rst", 8'(clamp_window), 8'h00);
    cyc(2);
    chk("sliced_idle", 8'(sliced), 8'h01);
    lvl = 5'h1f;
    wr = 1;
    cyc(1);
    wr = 0;
    ckc = 8'h04;
    pdc = 8'h18;
    ph = 5'h05;
    cyc(3);
    chk("slice_max", 8'(thr), 8'h1f);
    chk("ext_clk", 8'(ext_sel), 8'h01);
    chk("pd_force", 8'(power_down), 8'h01);
    chk("phase", 8'(pha), 8'h05);
    pdc = 8'h14;
    cyc(3);
    chk("pd_pin_low", 8'(power_down), 8'h00);
    pd_pin = 1;
    cyc(3);
    chk("pd_pin_high", 8'(power_down), 8'h01);
    $display("test config done");
    run = 1;
    lines(8'h30, 1, 1);
    chk("hs_lag", 8'(lag), 8'h07);
    dck_ref = dck_at;
    hs_pol = 1;
    lines(8'h20, 1, 0);
    lines(8'h00, 1, 1);
    chk("auto_high", 8'(pol_det), 8'h01);
    lines(8'h00, 0, 0);
    chk("auto_low", 8'(pol_det), 8'h00);
    ph = 5'h00;
    lines(8'h30, 1, 1);
    chk("hs_lag_zero", 8'(lag), 8'h02);
    chk("dck_align", 8'(dck_at), 8'(dck_ref));
    $display("test line edges done");
    ccc = 8'hc0;
    coast_in = 1;
    cyc(5);
    chk("coast_pin", 8'(coast_active), 8'h01);
    n_lock = 0;
    cyc(200);
    chk("coast_hold", 8'(n_lock), 8'h00);
    coast_in = 0;
    fp = 8'h30;
    frame_on = 1;
    cyc(3);
    chk("coast_frame", 8'(coast_active), 8'h01);
    frame_on = 0;
    cyc(5);
    $display("test coast done");
    n_clamp = 0;
    cyc(400);
    chk("clamp_int", 8'(n_clamp >= 50 && n_clamp <= 90), 8'h01);
    run = 0;
    cyc(50);
    ext_clamp_in = 1;
    cyc(3);
    chk("clamp_ignored", 8'(clamp_window), 8'h00);
    ccc = 8'hd0;
    cpc = 8'hc0;
    cyc(3);
    chk("clamp_ext", 8'(clamp_window), 8'h01);
    ext_clamp_in = 0;
    cyc(3);
    chk("clamp_ext_off", 8'(clamp_window), 8'h00);
    $display("test clamp done");
    lp = 8'h20;
    frame_on = 1;
    cyc(3);
    chk("field_set", 8'(field_odd), 8'h01);
    frame_on = 0;
    lp = 8'h30;
    cyc(2);
    frame_on = 1;
    cyc(3);
    chk("field_clr", 8'(field_odd), 8'h00);
    frame_on = 0;
    $display("test field done");
    ckc = 8'h00;
    cyc(5);
    n_dck = 0;
    cyc(20);
    chk("dck_pll", 8'(n_dck), 8'h0a);
    chk("ext_clk_off", 8'(ext_sel), 8'h00);
    en = 0;
    lvl = 5'h03;
    wr = 1;
    cyc(1);
    n_dck = 0;
    cyc(10);
    chk("freeze_clock", 8'(n_dck), 8'h00);
    en = 1;
    wr = 0;
    cyc(2);
    chk("freeze_slice", 8'(thr), 8'h1f);
    $display("test clock and enable done");
    test_done();
  end
endmodule // tb_sync_clamp_coast_front_end
